/* File: design/rdsm_pkg.sv */
`default_nettype none
// ==========================================================
// shared constants for the read-channel mode control block
package rdsm_pkg;
  // timing: bus clock and reference-clock loss window
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned REF_LOST_NS = 2000;
  // least time, so round up to whole cycles
  localparam int unsigned REF_LOST_CYC = (REF_LOST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned REF_CNT_W = 12;
  // preamble length before the found flag drops
  localparam int unsigned PREAMBLE_BYTES = 4;
  localparam int unsigned CELLS_PER_BYTE = 8;
  localparam int unsigned FOUND_CELLS = PREAMBLE_BYTES * CELLS_PER_BYTE;
  localparam int unsigned RUN_W = 6;
  localparam logic [RUN_W-1:0] FOUND_RUN = RUN_W'(FOUND_CELLS);
  // zero cells after each one: 1-0-0 and 1-0-0-0
  localparam logic [3:0] ZEROS_SHORT = 4'h2;
  localparam logic [3:0] ZEROS_LONG = 4'h3;
  localparam logic [3:0] GAP_MAX = 4'hF;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RUN = 8'h10;
  // control fields
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_PATTERN = 0;
  localparam int unsigned CTRL_TIMING = 1;
  localparam int unsigned CTRL_FAST = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // status fields
  localparam int unsigned STAT_W = 5;
  localparam int unsigned STAT_FOUND = 0;
  localparam int unsigned STAT_PF_MODE = 1;
  localparam int unsigned STAT_BOOST = 2;
  localparam int unsigned STAT_WINDOW = 3;
  localparam int unsigned STAT_REF_OK = 4;
  // interrupt fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_FOUND = 0;
  localparam int unsigned IRQ_CLOSE = 1;
  localparam int unsigned IRQ_REF_LOST = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // synchroniser lanes
  localparam int unsigned NSYNC = 6;
  localparam int unsigned S_FLUX = 0;
  localparam int unsigned S_RCLK = 1;
  localparam int unsigned S_REF = 2;
  localparam int unsigned S_WIN = 3;
  localparam int unsigned S_UP = 4;
  localparam int unsigned S_DN = 5;
  // preamble hunter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_FOUND = 3'b100
  } rdsm_det_state_t;
endpackage
`default_nettype wire

/* File: design/rdsm_cell_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// code cells from the retimer to the preamble hunter
interface rdsm_cell_if;
  import rdsm_pkg::*;
  logic cell_stb; // one cycle per recovered-clock cell
  logic cell_bit; // pulse seen in that cell
  logic pattern_long; // 1-0-0-0 when high
  logic window; // read window level
  logic enable; // reference clock alive
  logic found; // preamble recognised
  logic [RUN_W-1:0] run_len; // matching cells so far
  modport det(input cell_stb, cell_bit, pattern_long, window, enable, output found, run_len);
  modport ctl(output cell_stb, cell_bit, pattern_long, window, enable, input found, run_len);
endinterface
`default_nettype wire

/* File: design/rdsm_preamble_det.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// preamble hunter: counts cells that follow the chosen period
module rdsm_preamble_det
  import rdsm_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // cell stream
  rdsm_cell_if.det cif
);
  rdsm_det_state_t state_r, state_nxt; // hunter state
  logic [3:0] gap_r, gap_nxt; // zero cells since last one
  logic [RUN_W-1:0] run_r, run_nxt; // cells matching the period
  logic [3:0] zeros; // expected zeros per period
  logic [RUN_W:0] sum; // run plus one period, one bit wider

  assign zeros = cif.pattern_long ? ZEROS_LONG : ZEROS_SHORT;
  assign sum = {1'b0, run_r} + (RUN_W+1)'(zeros) + (RUN_W+1)'(1);

  // ==========================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    gap_nxt = gap_r;
    run_nxt = run_r;
    case (state_r)
      ST_IDLE: begin
        gap_nxt = '0;
        run_nxt = '0;
        if (cif.window) begin
          state_nxt = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (!cif.enable) begin
          // no reference clock: gating is dead, so no lock
          run_nxt = '0;
          gap_nxt = '0;
        end else if (cif.cell_stb && cif.cell_bit) begin
          gap_nxt = '0;
          // a one after exactly the right zeros extends the run
          if (gap_r == zeros) begin
            run_nxt = (sum >= (RUN_W+1)'(FOUND_RUN)) ? FOUND_RUN : sum[RUN_W-1:0];
          end else begin
            run_nxt = '0;
          end
        end else if (cif.cell_stb) begin
          gap_nxt = (gap_r == GAP_MAX) ? gap_r : gap_r + 4'h1;
          // too many zeros breaks the period
          if (gap_r >= zeros) begin
            run_nxt = '0;
          end
        end
        if (run_nxt == FOUND_RUN) begin
          state_nxt = ST_FOUND;
        end
        if (!cif.window) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FOUND: begin
        // held until the window closes
        if (!cif.window) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      gap_r <= '0;
      run_r <= '0;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      run_r <= run_nxt;
    end
  end

  assign cif.found = (state_r == ST_FOUND);
  assign cif.run_len = run_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_hunt_below_run: assert property (state_r == ST_HUNT |-> run_r < FOUND_RUN)
    else $error("hunter still hunting with full run");
  a_period_break: assert property (
    state_r == ST_HUNT && cif.window && cif.enable && cif.cell_stb && cif.cell_bit
    && gap_r != zeros |=> run_r == '0)
    else $error("wrong period did not clear run");
  a_found_drops: assert property (
    !cif.window && state_r == ST_FOUND |=> state_r == ST_IDLE)
    else $error("found held after window closed");
endmodule // rdsm_preamble_det
`default_nettype wire

/* File: design/rdsm_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rdsm_top
  import rdsm_pkg::*;
#(
  parameter int unsigned REF_LOST_CYCLES = REF_LOST_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // read channel inputs
  input wire logic read_window,
  input wire logic flux_pulse_in,
  input wire logic recovered_clock,
  input wire logic reference_clock_2x,
  input wire logic pc_up,
  input wire logic pc_dn,
  // read channel outputs
  output logic preamble_found_n,
  output logic phase_freq_mode,
  output logic boost_enable,
  output logic sync_data,
  output logic sync_clock,
  output logic phase_comp_or,
  // interrupt
  output logic irq
);
  // ==========================================================
  // elaboration checks
  if (REF_LOST_CYCLES < 2 || REF_LOST_CYCLES >= (1 << REF_CNT_W)) begin : g_bad_ref
    $error("REF_LOST_CYCLES out of range");
  end
  localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_LOST_CYCLES - 1);

  // ==========================================================
  // pin synchronisers: first stage feeds only the second
  logic [NSYNC-1:0] pins; // raw asynchronous pins
  logic [NSYNC-1:0] meta_r; // first stage
  logic [NSYNC-1:0] stab_r; // second stage, safe to use
  logic [NSYNC-1:0] prev_r; // delayed copy for edges
  assign pins = {pc_dn, pc_up, read_window, reference_clock_2x, recovered_clock, flux_pulse_in};

  // sampling only; recovered and reference clocks above half of hclk will alias
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      stab_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pins;
      stab_r <= meta_r;
      prev_r <= stab_r;
    end
  end

  logic win; // synced read window
  logic flux_rise; // flux reversal seen
  logic rclk_rise; // cell boundary
  logic ref_edge; // reference clock activity
  logic win_fall; // read window closed
  assign win = stab_r[S_WIN];
  assign flux_rise = stab_r[S_FLUX] & ~prev_r[S_FLUX];
  assign rclk_rise = stab_r[S_RCLK] & ~prev_r[S_RCLK];
  assign ref_edge = stab_r[S_REF] ^ prev_r[S_REF];
  assign win_fall = prev_r[S_WIN] & ~win;

  // ==========================================================
  // reference clock watchdog
  logic [REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt; // cycles since last edge
  logic ref_ok_r, ref_ok_nxt; // reference clock alive

  // missing reference stops the hunt, lock cannot happen
  always_comb begin
    ref_cnt_nxt = ref_cnt_r;
    ref_ok_nxt = ref_ok_r;
    if (ref_edge) begin
      ref_cnt_nxt = '0;
      ref_ok_nxt = 1'b1;
    end else if (ref_cnt_r == REF_LAST) begin
      ref_ok_nxt = 1'b0;
    end else begin
      ref_cnt_nxt = ref_cnt_r + REF_CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= '0;
      ref_ok_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      ref_ok_r <= ref_ok_nxt;
    end
  end

  // ==========================================================
  // retimer and preamble hunter
  logic pend_r, pend_nxt; // flux edge waiting for a cell
  logic sync_data_r, sync_data_nxt; // retimed pulse, one cell long
  logic sync_clock_r, sync_clock_nxt; // recovered clock, aligned
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt; // control register
  rdsm_cell_if cif();

  // an edge landing on a cell boundary is kept for the next cell
  always_comb begin
    pend_nxt = flux_rise | (pend_r & ~rclk_rise);
    sync_data_nxt = rclk_rise ? pend_r : sync_data_r;
    sync_clock_nxt = stab_r[S_RCLK];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      sync_data_r <= 1'b0;
      sync_clock_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      sync_data_r <= sync_data_nxt;
      sync_clock_r <= sync_clock_nxt;
    end
  end

  assign cif.cell_stb = rclk_rise;
  assign cif.cell_bit = pend_r;
  assign cif.pattern_long = ctrl_r[CTRL_PATTERN];
  assign cif.window = win;
  assign cif.enable = ref_ok_r;

  rdsm_preamble_det u_det (
    .hclk(hclk),
    .hresetn(hresetn),
    .cif(cif.det)
  );

  // ==========================================================
  // comparator mode, track rate, found flag
  logic pf_mode_r, pf_mode_nxt; // phase plus frequency when high
  logic boost_r, boost_nxt; // high track rate
  logic found_n_r, found_n_nxt; // active low found
  logic pc_or_r, pc_or_nxt; // comparator activity

  always_comb begin
    // outside the window always phase plus frequency
    // inside, timing low drops at once, high waits for found
    pf_mode_nxt = ~win | (ctrl_r[CTRL_TIMING] & ~cif.found);
    // rate follows the request only
    boost_nxt = ctrl_r[CTRL_FAST];
    found_n_nxt = ~(cif.found & win);
    pc_or_nxt = stab_r[S_UP] | stab_r[S_DN];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pf_mode_r <= 1'b1;
      boost_r <= 1'b0;
      found_n_r <= 1'b1;
      pc_or_r <= 1'b0;
    end else begin
      pf_mode_r <= pf_mode_nxt;
      boost_r <= boost_nxt;
      found_n_r <= found_n_nxt;
      pc_or_r <= pc_or_nxt;
    end
  end

  // ==========================================================
  // bus slave and register file
  logic take; // address phase accepted
  logic wr_r, wr_nxt; // write data phase pending
  logic [7:0] ofs_r, ofs_nxt; // latched write offset
  logic [31:0] rdata_r, rdata_nxt; // read data for data phase
  logic [IRQ_W-1:0] ist_r, ist_nxt; // sticky events
  logic [IRQ_W-1:0] imask_r, imask_nxt; // interrupt enables
  logic [IRQ_W-1:0] iclr; // write-one-to-clear bits
  logic [IRQ_W-1:0] ev; // event pulses
  logic irq_r, irq_nxt; // interrupt line
  logic [STAT_W-1:0] stat; // live status word

  assign take = hsel & htrans[1] & hready;
  assign stat = {ref_ok_r, win, boost_r, pf_mode_r, ~found_n_r};
  assign ev = {ref_ok_r & ~ref_ok_nxt, win_fall, cif.found & win & found_n_r};

  // writes land in the data phase; a read right behind a write sees the old value
  always_comb begin
    wr_nxt = take & hwrite & (hsize == HSIZE_WORD);
    ofs_nxt = take ? haddr[7:0] : ofs_r;
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    iclr = '0;
    if (wr_r) begin
      case (ofs_r)
        OFS_CTRL: ctrl_nxt = hwdata[CTRL_W-1:0];
        OFS_IRQ_STAT: iclr = hwdata[IRQ_W-1:0];
        OFS_IRQ_MASK: imask_nxt = hwdata[IRQ_W-1:0];
        default: iclr = '0; // read-only or unmapped: ignored
      endcase
    end
    // a new event beats a clear in the same cycle
    ist_nxt = (ist_r & ~iclr) | ev;
    irq_nxt = |(ist_nxt & imask_nxt);
    rdata_nxt = 32'h0;
    if (take && !hwrite) begin
      case (haddr[7:0])
        OFS_CTRL: rdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
        OFS_STATUS: rdata_nxt = {{(32-STAT_W){1'b0}}, stat};
        OFS_IRQ_STAT: rdata_nxt = {{(32-IRQ_W){1'b0}}, ist_r};
        OFS_IRQ_MASK: rdata_nxt = {{(32-IRQ_W){1'b0}}, imask_r};
        OFS_RUN: rdata_nxt = {{(32-RUN_W){1'b0}}, cif.run_len};
        default: rdata_nxt = 32'h0; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      ofs_r <= '0;
      ctrl_r <= CTRL_RESET;
      ist_r <= IRQ_RESET;
      imask_r <= IRQ_RESET;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      wr_r <= wr_nxt;
      ofs_r <= ofs_nxt;
      ctrl_r <= ctrl_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // zero wait states and OKAY always, so these are fixed flops
  logic ready_r; // held high after reset
  logic resp_r; // response code, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = rdata_r;
  assign hreadyout = ready_r;
  assign hresp = resp_r;
  assign preamble_found_n = found_n_r;
  assign phase_freq_mode = pf_mode_r;
  assign boost_enable = boost_r;
  assign sync_data = sync_data_r;
  assign sync_clock = sync_clock_r;
  assign phase_comp_or = pc_or_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_fast;
    win && !ctrl_r[CTRL_TIMING];
  endsequence
  sequence s_read_wait;
    win && ctrl_r[CTRL_TIMING] && !cif.found;
  endsequence

  a_mode_outside_pf: assert property (!win |=> pf_mode_r)
    else $error("phase-only outside read window");
  a_mode_fast_drop: assert property (s_read_fast |=> !pf_mode_r)
    else $error("comparator did not leave phase-frequency");
  a_mode_wait_found: assert property (s_read_wait |=> pf_mode_r)
    else $error("comparator left phase-frequency before found");
  a_found_holds_low: assert property (!found_n_r && win |=> !found_n_r)
    else $error("found released inside window");
  a_found_release: assert property (!win |=> found_n_r)
    else $error("found still low after window closed");
  a_boost_follow: assert property (
    ctrl_r[CTRL_FAST] != boost_r |=> boost_r == $past(ctrl_r[CTRL_FAST]))
    else $error("boost does not follow fast request");
  a_or_output: assert property ((stab_r[S_UP] || stab_r[S_DN]) |=> pc_or_r)
    else $error("comparator or output missed activity");
  a_retime_cell: assert property (pend_r && rclk_rise |=> sync_data_r)
    else $error("pending flux edge not retimed");
  a_retime_hold: assert property (!rclk_rise |=> $stable(sync_data_r))
    else $error("retimed data moved between cells");
endmodule // rdsm_top
`default_nettype wire

/* File: tb/rdsm_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far side: pulse detector, oscillator and reference source
module rdsm_partner (
  // clock
  input wire logic hclk,
  // stimulus control
  input wire logic ref_on,
  input wire logic pre_on,
  input wire logic pre_long,
  // pins toward the block
  output logic recovered_clock,
  output logic flux_pulse_in,
  output logic reference_clock_2x
);
  logic [1:0] ph_r; // phase in a cell of four hclk
  logic [1:0] pos_r; // cell index in one preamble period
  initial begin
    ph_r = 2'h0;
    pos_r = 2'h0;
    recovered_clock = 1'b0;
    flux_pulse_in = 1'b0;
    reference_clock_2x = 1'b0;
  end
  // oscillator runs free; kept slow so the block can sample it
  always @(posedge hclk) begin
    ph_r <= ph_r + 2'h1;
    recovered_clock <= ph_r[1];
    // reference stops only when the bench stages a loss
    if (ref_on && ph_r[0]) begin
      reference_clock_2x <= ~reference_clock_2x;
    end
    // one pulse opens each period, then two or three empty cells
    if (ph_r == 2'h0) begin
      flux_pulse_in <= pre_on && (pos_r == 2'h0);
    end
    if (ph_r == 2'h2) begin
      flux_pulse_in <= 1'b0;
      pos_r <= (pos_r == {1'b1, pre_long}) ? 2'h0 : pos_r + 2'h1;
    end
  end
endmodule // rdsm_partner
`default_nettype wire

/* File: tb/rdsm_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench: bus tasks, pin stimulus and looped preamble runs over select bit and sent period
module rdsm_top_tb;
  import rdsm_pkg::*;
  localparam int unsigned LOST = 4; // short loss window keeps runs brief
  // bus side
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  // read channel side
  logic read_window, pc_up, pc_dn, ref_on, pre_on, pre_long;
  logic rclk, flux, ref2x, found_n, pf_mode, boost, sdata, sclk, pc_or, irq;
  logic [5:0] outs; // pins in one vector for bounded waits
  int tests_run, miscompares, sd_cnt, sc_cnt, sd_0;
  assign outs = {irq, pc_or, boost, pf_mode, found_n, sdata};
  always #50 hclk = ~hclk;
  // counts cycles with retimed pulse and clock high
  always @(posedge hclk) begin
    sd_cnt <= sd_cnt + int'(sdata);
    sc_cnt <= sc_cnt + int'(sclk);
  end
  // ==========================================================
  // instances
  rdsm_top #(.REF_LOST_CYCLES(LOST)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .read_window(read_window), .flux_pulse_in(flux), .recovered_clock(rclk),
    .reference_clock_2x(ref2x), .pc_up(pc_up), .pc_dn(pc_dn),
    .preamble_found_n(found_n), .phase_freq_mode(pf_mode), .boost_enable(boost),
    .sync_data(sdata), .sync_clock(sclk), .phase_comp_or(pc_or), .irq(irq)
  );
  rdsm_partner far_u (
    .hclk(hclk), .ref_on(ref_on), .pre_on(pre_on), .pre_long(pre_long),
    .recovered_clock(rclk), .flux_pulse_in(flux), .reference_clock_2x(ref2x)
  );
  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("TB: counts run=%0d bad=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bounded wait for one pin level; running out ends the run
  task automatic wait_lvl(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[k] !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(outs[k], v);
    if (outs[k] !== v) results();
  endtask
  // one edge at least, then until hready is seen high
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      chk(hreadyout, 1'b1);
      results();
    end
  endtask
  // single word transfer; read data kept in rd_v
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    haddr <= {24'h0, a};
    for (i = 0; i < 2; i++) begin
      // address phase, then data phase, each held until hready
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
    end
    rd_v = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int k;
    logic pat, strm;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    haddr = 32'h0;
    hwdata = 32'h0;
    {read_window, pc_up, pc_dn, ref_on, pre_on, pre_long} = 6'h0;
    tests_run = 0;
    miscompares = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // reset levels, register reset values, unmapped read
    chk({hresp, hreadyout}, 2'h1);
    chk(outs, 6'h06);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_RUN, 32'h0);
    rd(8'h14, 32'h0);
    $display("TB: test reset done");
    // boost follows the request bit only; status is read-only
    bus(1'b1, OFS_CTRL, 32'h4);
    repeat (3) @(posedge hclk);
    chk(outs, 6'h0E);
    bus(1'b1, OFS_STATUS, 32'h0);
    rd(OFS_STATUS, 32'h6);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    chk(outs, 6'h06);
    $display("TB: test boost done");
    // either comparator output, and both, show on the or pin
    for (k = 1; k < 4; k++) begin
      {pc_dn, pc_up} <= k[1:0];
      wait_lvl(4, 1'b1, 8);
      {pc_dn, pc_up} <= 2'h0;
      wait_lvl(4, 1'b0, 8);
    end
    $display("TB: test compare or done");
    // window with timing low and no pulses: phase-only at once
    ref_on <= 1'b1;
    repeat (20) @(posedge hclk);
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    sd_0 = sd_cnt;
    read_window <= 1'b1;
    wait_lvl(2, 1'b0, 8);
    repeat (200) @(posedge hclk);
    chk(outs[1], 1'b1);
    chk(sd_cnt - sd_0, 0);
    read_window <= 1'b0;
    wait_lvl(2, 1'b1, 8);
    rd(OFS_IRQ_STAT, 32'h2);
    chk(outs[5], 1'b0);
    $display("TB: test window done");
    // select bit against the period actually sent, timing high
    for (k = 0; k < 4; k++) begin
      pat = k[0];
      strm = k[1];
      bus(1'b1, OFS_CTRL, {30'h0, 1'b1, pat});
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      pre_long <= strm;
      pre_on <= 1'b1;
      sd_0 = sd_cnt;
      read_window <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(outs[2:1], 2'h3);
      if (pat == strm) begin
        wait_lvl(1, 1'b0, 400);
        chk(outs[2:1], 2'h0);
        rd(OFS_RUN, 32'h20);
        chk(outs[5], 1'b1);
        chk(sd_cnt != sd_0, 1'b1);
        chk(sc_cnt > 0, 1'b1);
      end else begin
        // wrong spacing never completes a run
        repeat (400) @(posedge hclk);
        chk(outs[2:1], 2'h3);
      end
      read_window <= 1'b0;
      pre_on <= 1'b0;
      wait_lvl(1, 1'b1, 8);
      wait_lvl(2, 1'b1, 8);
      bus(1'b1, OFS_IRQ_STAT, 32'h7);
      repeat (2) @(posedge hclk);
      chk(outs[5], 1'b0);
    end
    $display("TB: test preamble done");
    // stopped reference flags an event and drops the ok bit
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    ref_on <= 1'b0;
    wait_lvl(5, 1'b1, LOST + 20);
    rd(OFS_STATUS, 32'h2);
    $display("TB: test reference done");
    results();
  end
endmodule // rdsm_top_tb
`default_nettype wire
